// ===== shared/cmb_pkg.sv
// constants and layout for the message buffer control block
package cmb_pkg;
   localparam int NUM_BUF = 32;
   localparam int BUF_W = 5;
   localparam int WORDS = 8;
   localparam int WORD_W = 3;
   localparam int HWORD_W = 16;
   localparam int ENTRY_W = 128;
   localparam int ADDR_W = 12;
   localparam int PAIR_W = 4;
   localparam int WORD_LSB = 2;
   localparam int BUF_LSB = 5;
   localparam int REGION_LSB = 10;
   localparam int REGION_W = 2;
   localparam logic [1:0] RAM_REGION = 2'h1;
   localparam logic [11:0] FULL_FLAGS_ADDR = 12'h040;
   localparam logic [11:0] OVF_FLAGS_ADDR = 12'h044;
   localparam logic [11:0] OFFER_ADDR = 12'h048;
   localparam int OFFER_VALID_BIT = 31;
   localparam int PAIR_HI_LSB = 8;
   localparam int CTRL_W = 8;
   localparam int B_IS_TX = 7;
   localparam int B_ABT = 6;
   localparam int B_LARB = 5;
   localparam int B_ERR = 4;
   localparam int B_REQ = 3;
   localparam int B_RTR = 2;
   localparam int PRIO_LSB = 0;
   localparam int PRIO_W = 2;
   localparam logic [1:0] PRIO_RST = 2'h0;
   localparam logic [2:0] W_SID = 3'h0;
   localparam logic [2:0] W_EID = 3'h1;
   localparam logic [2:0] W_DLC = 3'h2;
   localparam logic [2:0] W_STAT = 3'h7;
   localparam logic [15:0] SID_MASK = 16'h1FFF;
   localparam logic [15:0] EID_MASK = 16'h0FFF;
   localparam logic [15:0] DLC_MASK = 16'hFF1F;
   localparam logic [15:0] STAT_MASK = 16'h1F00;
   localparam logic [15:0] FULL_MASK = 16'hFFFF;
   localparam int FILT_LSB = 8;
   localparam int FILT_W = 5;
endpackage

// ===== shared/cmb_msg_if.sv
// links control logic to message ram and transmit selector
`timescale 1ns/1ps
interface cmb_msg_if;
   logic sw_we;
   logic sw_rd_en;
   logic [cmb_pkg::BUF_W-1:0] sw_buf;
   logic [cmb_pkg::WORD_W-1:0] sw_word;
   logic [cmb_pkg::HWORD_W-1:0] sw_wdata;
   logic [cmb_pkg::HWORD_W-1:0] sw_rdata;
   logic hw_we;
   logic [cmb_pkg::BUF_W-1:0] hw_buf;
   logic [cmb_pkg::ENTRY_W-1:0] hw_entry;
   logic [cmb_pkg::BUF_W-1:0] tx_buf;
   logic [cmb_pkg::ENTRY_W-1:0] tx_entry;
   logic [cmb_pkg::NUM_BUF-1:0] cand;
   logic [2*cmb_pkg::NUM_BUF-1:0] prio;
   logic sel_valid;
   logic [cmb_pkg::BUF_W-1:0] sel_idx;
   modport ctl (output sw_we, sw_rd_en, sw_buf, sw_word, sw_wdata, hw_we, hw_buf, hw_entry,
      tx_buf, cand, prio, input sw_rdata, tx_entry, sel_valid, sel_idx);
   modport ram_mp (input sw_we, sw_rd_en, sw_buf, sw_word, sw_wdata, hw_we, hw_buf, hw_entry,
      tx_buf, output sw_rdata, tx_entry);
   modport sel_mp (input cand, prio, output sel_valid, sel_idx);
endinterface

// ===== logic/cmb_msg_ram.sv
// message ram holding the buffer words of every message buffer
`timescale 1ns/1ps
module cmb_msg_ram #(
   parameter int NUM_BUF = cmb_pkg::NUM_BUF
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   cmb_msg_if.ram_mp mif
);
   logic [cmb_pkg::ENTRY_W-1:0] mem_r [NUM_BUF];
   logic [cmb_pkg::HWORD_W-1:0] sw_rdata_r;
   logic [cmb_pkg::ENTRY_W-1:0] tx_entry_r;
   logic [6:0] lane;

   assign lane = {mif.sw_word, 4'h0};

   // receive writes take the whole entry
   always_ff @(posedge core_clk_i) begin
      if (mif.hw_we) begin
         mem_r[mif.hw_buf] <= mif.hw_entry;
      end else if (mif.sw_we) begin
         mem_r[mif.sw_buf][lane +: cmb_pkg::HWORD_W] <= mif.sw_wdata;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sw_rdata_r <= '0;
         tx_entry_r <= '0;
      end else begin
         if (mif.sw_rd_en) begin
            sw_rdata_r <= mem_r[mif.sw_buf][lane +: cmb_pkg::HWORD_W];
         end
         tx_entry_r <= mem_r[mif.tx_buf];
      end
   end

   assign mif.sw_rdata = sw_rdata_r;
   assign mif.tx_entry = tx_entry_r;
endmodule // cmb_msg_ram

// ===== logic/cmb_tx_select.sv
// picks the pending transmit buffer to offer next
`timescale 1ns/1ps
module cmb_tx_select #(
   parameter int NUM_BUF = cmb_pkg::NUM_BUF
) (
   cmb_msg_if.sel_mp mif
);
   logic found;
   logic [cmb_pkg::BUF_W-1:0] best_idx;
   logic [cmb_pkg::PRIO_W-1:0] best_prio;

   always_comb begin
      found = 1'b0;
      best_idx = '0;
      best_prio = '0;
      for (int i = 0; i < NUM_BUF; i++) begin
         if (mif.cand[i] && (!found || mif.prio[2*i +: 2] > best_prio)) begin
            found = 1'b1;
            best_idx = cmb_pkg::BUF_W'(i);
            best_prio = mif.prio[2*i +: 2];
         end
      end
   end

   assign mif.sel_valid = found;
   assign mif.sel_idx = best_idx;
endmodule // cmb_tx_select

// ===== logic/cmb_buffer_control.sv
// message buffer control registers, apb slave and buffer bookkeeping
// Functional notes
// - buffer select bit set makes a transmit buffer, clear a receive buffer
// - one pair word per two buffers; low byte even, high byte odd
// - aborted flag set on abort, stays clear on successful completion
// - lost-arbitration flag set when the message loses arbitration
// - transmit-error flag set when a bus error hits the message
// - setting send request clears aborted, lost-arbitration and error flags
// - software sets send request; device clears it once sent
// - writing send request to 0 while set requests an abort
// - remote request received with auto-answer set raises send request
// - two-bit priority: 11 highest down to 00 lowest
// - first word: standard id in bits 12..2, bits 15..13 read zero
// - first word bit 1 is the substitute remote request flag
// - first word bit 0 selects extended identifier format
// - second word: extended id 17..6 in bits 11..0, top four zero
// - third word: extended id 5..0 in bits 15..10
// - third word bit 9 is the remote transmission request flag
// - third word low four bits hold length code, bits 7..5 zero
// - eight data bytes, two per word, odd byte in upper half
// - receive buffers get matched filter number in status bits 12..8
// - buffer words live in message ram, apart from control registers
// - thirty-two buffers numbered 0 to 31, identical layout
// - device sets full flag on receive; software clears it
// - receive into a full buffer sets the overflow flag
`timescale 1ns/1ps
module cmb_buffer_control (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic tx_offer_valid_o,
   output logic [4:0] tx_offer_buf_o,
   output logic [127:0] tx_msg_o,
   output logic [31:0] tx_abort_req_o,
   output logic [31:0] buffer_is_transmit_o,
   input wire logic [4:0] tx_evt_buf_i,
   input wire logic tx_done_i,
   input wire logic tx_abort_done_i,
   input wire logic tx_lost_arb_i,
   input wire logic tx_bus_err_i,
   input wire logic rtr_rx_i,
   input wire logic [4:0] rtr_buf_i,
   input wire logic rx_wr_i,
   input wire logic [4:0] rx_buf_i,
   input wire logic [4:0] rx_filter_i,
   input wire logic [15:0] rx_sid_word_i,
   input wire logic [15:0] rx_eid_word_i,
   input wire logic [15:0] rx_dlc_word_i,
   input wire logic [63:0] rx_data_i
);
   localparam int NB = cmb_pkg::NUM_BUF;

   cmb_msg_if mif();

   logic ready_r;
   logic [31:0] prdata_r;
   logic first_acc;
   logic acc;
   logic wr_acc;
   logic [11:0] word_addr;
   logic [cmb_pkg::PAIR_W-1:0] pair_sel;
   logic is_ctrl;
   logic is_ram;
   logic is_full;
   logic is_ovf;
   logic is_offer;
   logic mapped;
   logic [31:0] rd_mux;
   logic [15:0] sw_mask;
   logic [cmb_pkg::CTRL_W-1:0] ctrl_byte [NB];
   logic [NB-1:0] is_tx_v;
   logic [NB-1:0] req_v;
   logic [NB-1:0] pend_v;
   logic [NB-1:0] full_v;
   logic [NB-1:0] ovf_v;
   logic [NB-1:0] clr_full;
   logic [NB-1:0] clr_ovf;
   logic [2*NB-1:0] prio_v;
   logic rx_ok;
   logic offer_valid_r;
   logic [cmb_pkg::BUF_W-1:0] offer_buf_r;
   logic [15:0] rx_stat;

   // apb phases: setup, first access (wait), second access (ready)
   assign first_acc = psel_i & penable_i & ~ready_r;
   assign acc = psel_i & penable_i & ready_r;
   assign wr_acc = acc & pwrite_i;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= first_acc;
      end
   end

   assign pready_o = ready_r;
   assign pslverr_o = ready_r & ~mapped;

   // address decode
   assign word_addr = {paddr_i[cmb_pkg::ADDR_W-1:cmb_pkg::WORD_LSB], 2'h0};
   assign pair_sel = paddr_i[cmb_pkg::WORD_LSB +: cmb_pkg::PAIR_W];
   assign is_ctrl = paddr_i[cmb_pkg::ADDR_W-1:cmb_pkg::WORD_LSB+cmb_pkg::PAIR_W] == '0;
   // buffer words in a separate ram region
   assign is_ram = paddr_i[cmb_pkg::REGION_LSB +: cmb_pkg::REGION_W] == cmb_pkg::RAM_REGION;
   assign is_full = word_addr == cmb_pkg::FULL_FLAGS_ADDR;
   assign is_ovf = word_addr == cmb_pkg::OVF_FLAGS_ADDR;
   assign is_offer = word_addr == cmb_pkg::OFFER_ADDR;
   assign mapped = is_ctrl | is_ram | is_full | is_ovf | is_offer;

   always_comb begin
      unique case (mif.sw_word)
         cmb_pkg::W_SID: sw_mask = cmb_pkg::SID_MASK;
         cmb_pkg::W_EID: sw_mask = cmb_pkg::EID_MASK;
         cmb_pkg::W_DLC: sw_mask = cmb_pkg::DLC_MASK;
         cmb_pkg::W_STAT: sw_mask = cmb_pkg::STAT_MASK;
         default: sw_mask = cmb_pkg::FULL_MASK;
      endcase
   end

   // software side of the message ram
   assign mif.sw_buf = paddr_i[cmb_pkg::BUF_LSB +: cmb_pkg::BUF_W];
   assign mif.sw_word = paddr_i[cmb_pkg::WORD_LSB +: cmb_pkg::WORD_W];
   assign mif.sw_rd_en = psel_i & ~penable_i & is_ram;
   assign mif.sw_we = wr_acc & is_ram;
   assign mif.sw_wdata = pwdata_i[cmb_pkg::HWORD_W-1:0] & sw_mask;

   // read data mux
   always_comb begin
      rd_mux = '0;
      if (is_ctrl) begin
         rd_mux[cmb_pkg::PAIR_HI_LSB +: cmb_pkg::CTRL_W] = ctrl_byte[{pair_sel, 1'b1}];
         rd_mux[cmb_pkg::CTRL_W-1:0] = ctrl_byte[{pair_sel, 1'b0}];
      end else if (is_ram) begin
         rd_mux[cmb_pkg::HWORD_W-1:0] = mif.sw_rdata;
      end else if (is_full) begin
         rd_mux = full_v;
      end else if (is_ovf) begin
         rd_mux = ovf_v;
      end else if (is_offer) begin
         rd_mux[cmb_pkg::OFFER_VALID_BIT] = offer_valid_r;
         rd_mux[cmb_pkg::BUF_W-1:0] = offer_buf_r;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_r <= '0;
      end else if (first_acc && !pwrite_i) begin
         prdata_r <= rd_mux;
      end
   end

   assign prdata_o = prdata_r;

   // receive entry: status, data, length, ids
   assign rx_stat = cmb_pkg::HWORD_W'(rx_filter_i) << cmb_pkg::FILT_LSB;
   assign rx_ok = rx_wr_i & ~is_tx_v[rx_buf_i];
   // a full buffer is not overwritten
   assign mif.hw_we = rx_ok & ~full_v[rx_buf_i];
   assign mif.hw_buf = rx_buf_i;
   assign mif.hw_entry = {rx_stat, rx_data_i, rx_dlc_word_i & cmb_pkg::DLC_MASK,
      rx_eid_word_i & cmb_pkg::EID_MASK, rx_sid_word_i & cmb_pkg::SID_MASK};

   // full and overflow clear: writing 0 to a bit clears it
   assign clr_full = (wr_acc && is_full) ? ~pwdata_i : '0;
   assign clr_ovf = (wr_acc && is_ovf) ? ~pwdata_i : '0;

   for (genvar i = 0; i < NB; i++) begin : g_buf
      // even buffers use the low byte, odd the high byte
      localparam int LANE = (i % 2) * cmb_pkg::PAIR_HI_LSB;
      logic wr;
      logic [cmb_pkg::CTRL_W-1:0] wbyte;
      logic hit;
      logic set_req;
      logic clr_req;
      logic rtr_hit;
      logic rx_hit;
      logic is_tx_r;
      logic abt_r;
      logic larb_r;
      logic err_r;
      logic req_r;
      logic rtr_en_r;
      logic pend_r;
      logic full_r;
      logic ovf_r;
      logic [cmb_pkg::PRIO_W-1:0] prio_r;

      assign wr = wr_acc & is_ctrl & (pair_sel == cmb_pkg::PAIR_W'(i / 2));
      assign wbyte = pwdata_i[LANE +: cmb_pkg::CTRL_W];
      assign hit = tx_evt_buf_i == cmb_pkg::BUF_W'(i);
      // remote request raises send request when enabled
      assign rtr_hit = rtr_rx_i & (rtr_buf_i == cmb_pkg::BUF_W'(i)) & rtr_en_r;
      assign set_req = (wr & wbyte[cmb_pkg::B_REQ] & ~req_r) | rtr_hit;
      // clearing a set request asks for abort
      assign clr_req = wr & ~wbyte[cmb_pkg::B_REQ] & req_r;
      assign rx_hit = rx_ok & (rx_buf_i == cmb_pkg::BUF_W'(i));

      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            is_tx_r <= 1'b0;
            rtr_en_r <= 1'b0;
            prio_r <= cmb_pkg::PRIO_RST;
         end else if (wr) begin
            is_tx_r <= wbyte[cmb_pkg::B_IS_TX];
            rtr_en_r <= wbyte[cmb_pkg::B_RTR];
            prio_r <= wbyte[cmb_pkg::PRIO_LSB +: cmb_pkg::PRIO_W];
         end
      end

      // device clears request after success or abort
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            req_r <= 1'b0;
         end else if (set_req) begin
            req_r <= 1'b1;
         end else if (hit && (tx_done_i || tx_abort_done_i)) begin
            req_r <= 1'b0;
         end
      end

      // abort pending until the engine reports the outcome
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            pend_r <= 1'b0;
         end else if (set_req || (hit && (tx_done_i || tx_abort_done_i))) begin
            pend_r <= 1'b0;
         end else if (clr_req) begin
            pend_r <= 1'b1;
         end
      end

      // outcome flags; events win over the clear
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            abt_r <= 1'b0;
            larb_r <= 1'b0;
            err_r <= 1'b0;
         end else begin
            if (hit && tx_abort_done_i) begin
               abt_r <= 1'b1;
            end else if (set_req) begin
               abt_r <= 1'b0;
            end
            if (hit && tx_lost_arb_i) begin
               larb_r <= 1'b1;
            end else if (set_req) begin
               larb_r <= 1'b0;
            end
            if (hit && tx_bus_err_i) begin
               err_r <= 1'b1;
            end else if (set_req) begin
               err_r <= 1'b0;
            end
         end
      end

      // receive full and overflow; set wins over clear
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            full_r <= 1'b0;
            ovf_r <= 1'b0;
         end else begin
            if (rx_hit) begin
               full_r <= 1'b1;
            end else if (clr_full[i]) begin
               full_r <= 1'b0;
            end
            if (rx_hit && full_r) begin
               ovf_r <= 1'b1;
            end else if (clr_ovf[i]) begin
               ovf_r <= 1'b0;
            end
         end
      end

      assign ctrl_byte[i] = {is_tx_r, abt_r, larb_r, err_r, req_r, rtr_en_r, prio_r};
      assign is_tx_v[i] = is_tx_r;
      assign req_v[i] = req_r;
      assign pend_v[i] = pend_r;
      assign full_v[i] = full_r;
      assign ovf_v[i] = ovf_r;
      assign prio_v[2*i +: 2] = prio_r;
   end

   // candidates: pending transmit buffers not being aborted
   assign mif.cand = is_tx_v & req_v & ~pend_v;
   assign mif.prio = prio_v;
   assign mif.tx_buf = offer_buf_r;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         offer_valid_r <= 1'b0;
         offer_buf_r <= '0;
      end else begin
         offer_valid_r <= mif.sel_valid;
         offer_buf_r <= mif.sel_idx;
      end
   end

   assign tx_offer_valid_o = offer_valid_r;
   assign tx_offer_buf_o = offer_buf_r;
   assign tx_msg_o = mif.tx_entry;
   assign tx_abort_req_o = pend_v;
   assign buffer_is_transmit_o = is_tx_v;

   cmb_msg_ram #(
      .NUM_BUF(NB)
   ) u_ram (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .mif(mif.ram_mp)
   );

   cmb_tx_select #(
      .NUM_BUF(NB)
   ) u_sel (
      .mif(mif.sel_mp)
   );
endmodule // cmb_buffer_control

// ===== tb/cmb_buffer_control_assertions.sv
// port assertions for the buffer control block
`timescale 1ns/1ps
module cmb_bc_assertions (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [31:0] tx_abort_req_o,
   input wire logic [31:0] buffer_is_transmit_o,
   input wire logic [4:0] tx_evt_buf_i,
   input wire logic tx_done_i,
   input wire logic tx_abort_done_i
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_setup;
      psel_i && !penable_i ##1 psel_i && penable_i;
   endsequence
   sequence s_answer;
      !pready_o ##1 pready_o;
   endsequence
   property p_wait; s_setup |-> s_answer; endproperty
   a_wait: assert property (p_wait)
      else $error("answer not after one wait state");
   property p_pulse; pready_o |=> !pready_o; endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready longer than one cycle");
   property p_inacc; pready_o |-> psel_i && penable_i; endproperty
   a_inacc: assert property (p_inacc)
      else $error("ready outside access phase");
   property p_erronly; pslverr_o |-> pready_o; endproperty
   a_erronly: assert property (p_erronly)
      else $error("error without ready");
   property p_unmap; pready_o && paddr_i[11:2] == 10'h013 |-> pslverr_o; endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped access not refused");
   property p_rdata; $changed(prdata_o) |-> pready_o && !pwrite_i; endproperty
   a_rdata: assert property (p_rdata)
      else $error("read data moved outside a read");
   property p_seltx;
      $changed(buffer_is_transmit_o) |-> $past(pready_o && pwrite_i && paddr_i[11:6] == 6'h0);
   endproperty
   a_seltx: assert property (p_seltx)
      else $error("buffer select changed without write");
   property p_abtrise;
      (tx_abort_req_o & ~$past(tx_abort_req_o)) != 32'h0 |-> $past(pready_o && pwrite_i);
   endproperty
   a_abtrise: assert property (p_abtrise)
      else $error("abort request without write");
   property p_abtdone; tx_abort_done_i |=> !tx_abort_req_o[$past(tx_evt_buf_i)]; endproperty
   a_abtdone: assert property (p_abtdone)
      else $error("abort request kept after abort done");
   property p_done; tx_done_i |=> !tx_abort_req_o[$past(tx_evt_buf_i)]; endproperty
   a_done: assert property (p_done)
      else $error("abort request kept after send done");
endmodule // cmb_bc_assertions
bind cmb_buffer_control cmb_bc_assertions u_chk (.core_clk_i(core_clk_i),
   .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .tx_abort_req_o(tx_abort_req_o), .buffer_is_transmit_o(buffer_is_transmit_o),
   .tx_evt_buf_i(tx_evt_buf_i), .tx_done_i(tx_done_i), .tx_abort_done_i(tx_abort_done_i));

// ===== tb/cmb_can_node.sv
// bus side model: protocol engine outcomes and received frames
`timescale 1ns/1ps
module cmb_can_node (
   input wire logic core_clk_i,
   output logic [4:0] evt_buf_o,
   output logic [5:0] pulse_o,
   output logic [4:0] filt_o,
   output logic [15:0] sid_o,
   output logic [15:0] eid_o,
   output logic [15:0] dlc_o,
   output logic [63:0] data_o
);
   bit busy = 0;
   initial begin
      {evt_buf_o, pulse_o, filt_o, sid_o, eid_o, dlc_o, data_o} = '0;
   end
   // idle buffer, filter and frame lines toggle every cycle; pulse lines stay low
   always @(posedge core_clk_i) begin
      if (!busy) begin
         evt_buf_o <= ~evt_buf_o;
         filt_o <= ~filt_o;
         {sid_o, eid_o, dlc_o, data_o} <= ~{sid_o, eid_o, dlc_o, data_o};
      end
   end
   task automatic ev(input int k, input logic [4:0] b, input logic [4:0] f,
      input logic [15:0] s, input logic [15:0] e, input logic [15:0] d, input logic [63:0] x);
      busy = 1;
      @(posedge core_clk_i);
      evt_buf_o <= b;
      filt_o <= f;
      {sid_o, eid_o, dlc_o, data_o} <= {s, e, d, x};
      pulse_o[k] <= 1'b1;
      @(posedge core_clk_i);
      pulse_o <= '0;
      busy = 0;
   endtask
endmodule // cmb_can_node

// ===== tb/cmb_buffer_control_tb_top.sv
// self-checking bench for the buffer control block
`timescale 1ns/1ps
module cmb_buffer_control_tb_top;
   logic core_clk_i = 0;
   logic reset_n_i = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, ovld;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, abrt, istx, q;
   logic [4:0] obuf, ebuf, filt;
   logic [127:0] msg;
   logic [5:0] pl;
   logic [15:0] sw, ew, dw, sid, eid, dlc;
   logic [63:0] dd, dat;
   logic [15:0] mem [32][8];
   logic [15:0] e [8];
   int mismatches = 0, cmp_count = 0, cyc = 0;
   always #10 core_clk_i = ~core_clk_i;
   cmb_buffer_control dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_offer_valid_o(ovld),
      .tx_offer_buf_o(obuf), .tx_msg_o(msg), .tx_abort_req_o(abrt),
      .buffer_is_transmit_o(istx), .tx_evt_buf_i(ebuf), .tx_done_i(pl[0]),
      .tx_abort_done_i(pl[1]), .tx_lost_arb_i(pl[2]), .tx_bus_err_i(pl[3]), .rtr_rx_i(pl[4]),
      .rtr_buf_i(ebuf), .rx_wr_i(pl[5]), .rx_buf_i(ebuf), .rx_filter_i(filt),
      .rx_sid_word_i(sw), .rx_eid_word_i(ew), .rx_dlc_word_i(dw), .rx_data_i(dd));
   cmb_can_node node (.core_clk_i(core_clk_i), .evt_buf_o(ebuf), .pulse_o(pl), .filt_o(filt),
      .sid_o(sw), .eid_o(ew), .dlc_o(dw), .data_o(dd));
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input logic [127:0] s, input logic [127:0] x);
      cmp_count++;
      if (s !== x) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   // setup, then access held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge core_clk_i);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   function automatic logic [7:0] cb(logic t, a, l, r, s, n, logic [1:0] p);
      return {t, a, l, r, s, n, p};
   endfunction
   function automatic logic [11:0] ra(int b, int w);
      return 12'h400 + 12'(b * 32 + w * 4);
   endfunction
   function automatic logic [15:0] wm(int w);
      case (w)
         0: return cmb_pkg::SID_MASK;
         1: return cmb_pkg::EID_MASK;
         2: return cmb_pkg::DLC_MASK;
         7: return cmb_pkg::STAT_MASK;
         default: return cmb_pkg::FULL_MASK;
      endcase
   endfunction
   initial begin
      int b, w;
      logic [31:0] d;
      logic [127:0] x;
      logic [7:0] lo;
      d = $urandom(32'hFAE8A7A6);
      repeat (5) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      for (int p = 0; p < 16; p++) rd(12'(4 * p), 32'h0);
      rd(cmb_pkg::FULL_FLAGS_ADDR, 32'h0);
      rd(12'h04C, 32'h0);
      chk(err, 1'b1);
      for (int i = 0; i < 24; i++) begin
         b = (i < 8) ? 0 : (i < 16) ? 31 : $urandom % 32;
         w = i % 8;
         d = $urandom & ((w == 2) ? 32'hFFFFFEEF : 32'hFFFFFFFF);
         mem[b][w] = d[15:0] & wm(w);
         wr(ra(b, w), d);
         rd(ra(b, w), {16'h0, mem[b][w]});
      end
      for (int p = 0; p < 4; p++) begin
         wr(12'h000, {16'h0, cb(1, 0, 0, 0, 1, 0, 2'h2), cb(1, 0, 0, 0, 1, 0, 2'(p))});
         rd(cmb_pkg::OFFER_ADDR, {1'b1, 26'h0, (p >= 2) ? 5'h0 : 5'h1});
      end
      chk(istx, 32'h3);
      chk({ovld, obuf}, 6'h20);
      for (int k = 0; k < 8; k++) x[16 * k +: 16] = mem[0][k];
      chk(msg, x);
      lo = cb(1, 0, 0, 0, 1, 0, 2'h3);
      node.ev(2, 5'h1, 5'h0, 16'h0, 16'h0, 16'h0, 64'h0);
      rd(12'h000, {16'h0, cb(1, 0, 1, 0, 1, 0, 2'h2), lo});
      node.ev(3, 5'h1, 5'h0, 16'h0, 16'h0, 16'h0, 64'h0);
      rd(12'h000, {16'h0, cb(1, 0, 1, 1, 1, 0, 2'h2), lo});
      wr(12'h000, {16'h0, cb(1, 0, 0, 0, 0, 0, 2'h2), lo});
      rd(12'h000, {16'h0, cb(1, 0, 1, 1, 1, 0, 2'h2), lo});
      chk(abrt, 32'h2);
      node.ev(1, 5'h1, 5'h0, 16'h0, 16'h0, 16'h0, 64'h0);
      rd(12'h000, {16'h0, cb(1, 1, 1, 1, 0, 0, 2'h2), lo});
      chk(abrt, 32'h0);
      wr(12'h000, {16'h0, cb(1, 0, 0, 0, 1, 0, 2'h2), lo});
      rd(12'h000, {16'h0, cb(1, 0, 0, 0, 1, 0, 2'h2), lo});
      node.ev(0, 5'h1, 5'h0, 16'h0, 16'h0, 16'h0, 64'h0);
      rd(12'h000, {16'h0, cb(1, 0, 0, 0, 0, 0, 2'h2), lo});
      wr(12'h000, {16'h0, cb(1, 0, 0, 0, 0, 1, 2'h2), lo});
      wr(12'h004, {24'h0, cb(1, 0, 0, 0, 0, 0, 2'h0)});
      node.ev(4, 5'h1, 5'h0, 16'h0, 16'h0, 16'h0, 64'h0);
      node.ev(4, 5'h2, 5'h0, 16'h0, 16'h0, 16'h0, 64'h0);
      rd(12'h000, {16'h0, cb(1, 0, 0, 0, 1, 1, 2'h2), lo});
      rd(12'h004, {24'h0, cb(1, 0, 0, 0, 0, 0, 2'h0)});
      sid = 16'($urandom) & cmb_pkg::SID_MASK;
      eid = 16'($urandom) & cmb_pkg::EID_MASK;
      dlc = 16'($urandom) & cmb_pkg::DLC_MASK & 16'hFEEF;
      dat = {$urandom, $urandom};
      node.ev(5, 5'hA, 5'hD, sid, eid, dlc, dat);
      node.ev(5, 5'hA, 5'h7, eid, sid, dlc, ~dat);
      node.ev(5, 5'h2, 5'h4, sid, eid, dlc, dat);
      rd(cmb_pkg::FULL_FLAGS_ADDR, 32'h400);
      rd(cmb_pkg::OVF_FLAGS_ADDR, 32'h400);
      e = '{sid, eid, dlc, dat[15:0], dat[31:16], dat[47:32], dat[63:48], {3'h0, 5'hD, 8'h0}};
      for (int k = 0; k < 8; k++) rd(ra(10, k), {16'h0, e[k]});
      wr(cmb_pkg::FULL_FLAGS_ADDR, 32'hFFFFFBFF);
      wr(cmb_pkg::OVF_FLAGS_ADDR, 32'hFFFFFBFF);
      rd(cmb_pkg::FULL_FLAGS_ADDR, 32'h0);
      rd(cmb_pkg::OVF_FLAGS_ADDR, 32'h0);
      give_verdict();
   end
endmodule // cmb_buffer_control_tb_top
